// file: lsc_pkg.sv
package lsc_pkg;
  localparam logic [7:0] LSC_DARK_DIM_ADDR = 8'h0e;
  localparam logic [7:0] LSC_FADE_LAW_ADDR = 8'h0f;
  localparam logic [7:0] LSC_ENABLE_ADDR = 8'h10;
  localparam logic [7:0] LSC_TIMING1_ADDR = 8'h11;
  localparam logic [7:0] LSC_DIM_MASK = 8'h7f;
  localparam logic [7:0] LSC_LAW_MASK = 8'h03;
  localparam logic [7:0] LSC_EN_MASK = 8'h7f;
  localparam logic [7:0] LSC_RESET_VAL = 8'h00;
  localparam int LSC_NUM_SINKS = 7;
  localparam int LSC_BLINK_SINKS = 3;
  localparam int LSC_CLK_HZ = 40000000;
  // timing unit of 0.2 s expressed in milliseconds
  localparam int LSC_TICK_MS = 200;
  localparam int LSC_TICK_CYCLES = LSC_CLK_HZ / 1000 * LSC_TICK_MS;
  // on-time codes 0.2/0.6/0.8/1.2 s in ticks
  localparam logic [3:0] LSC_ON_TICKS_0 = 4'h1;
  localparam logic [3:0] LSC_ON_TICKS_1 = 4'h3;
  localparam logic [3:0] LSC_ON_TICKS_2 = 4'h4;
  localparam logic [3:0] LSC_ON_TICKS_3 = 4'h6;
  // off-time codes 0.6/1.2/1.8 s in ticks
  localparam logic [3:0] LSC_OFF_TICKS_1 = 4'h3;
  localparam logic [3:0] LSC_OFF_TICKS_2 = 4'h6;
  localparam logic [3:0] LSC_OFF_TICKS_3 = 4'h9;
  typedef enum logic [1:0] {
    LSC_LAW_LIN = 2'h0,
    LSC_LAW_SQR = 2'h1,
    LSC_LAW_CUBIC_A = 2'h2,
    LSC_LAW_CUBIC_B = 2'h3
  } lsc_law_type;
endpackage

// file: lsc_regs.sv
`timescale 1ns/10ps
`default_nettype none
module lsc_regs
  import lsc_pkg::*;
#(
  parameter int TICK_CYCLES = LSC_TICK_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_dim_timeout,
  input wire logic i_dim_force,
  output logic [7:0] o_rdata,
  output logic o_dim_active,
  output logic [6:0] o_dark_dim_code,
  output logic [1:0] o_sink_fade_law,
  output logic [6:0] o_sink_on
);
  // one-hot phase of a blinking sink
  typedef enum logic [1:0] {
    LSC_PHASE_ON = 2'b01,
    LSC_PHASE_OFF = 2'b10
  } lsc_phase_type;

  logic [7:0] dark_dim_current_reg;
  logic [7:0] sink_fade_law_ctrl_reg;
  logic [7:0] sink_enable_ctrl_reg;
  logic [7:0] sink_timing_first_reg;
  logic [31:0] tick_cnt_reg;
  logic tick;
  logic [LSC_BLINK_SINKS-1:0] phase_on;
  logic [7:0] rdata_next;
  logic [1:0] on_code;
  logic [3:0] on_ticks;
  logic wr_dim;
  logic wr_law;
  logic wr_enable;
  logic wr_timing;

  // write decode, one strobe per register
  assign wr_dim = i_wr_en && (i_addr == LSC_DARK_DIM_ADDR);
  assign wr_law = i_wr_en && (i_addr == LSC_FADE_LAW_ADDR);
  assign wr_enable = i_wr_en && (i_addr == LSC_ENABLE_ADDR);
  assign wr_timing = i_wr_en && (i_addr == LSC_TIMING1_ADDR);

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      dark_dim_current_reg <= LSC_RESET_VAL;
    end else if (wr_dim) begin
      dark_dim_current_reg <= i_wdata & LSC_DIM_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sink_fade_law_ctrl_reg <= LSC_RESET_VAL;
    end else if (wr_law) begin
      sink_fade_law_ctrl_reg <= i_wdata & LSC_LAW_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sink_enable_ctrl_reg <= LSC_RESET_VAL;
    end else if (wr_enable) begin
      sink_enable_ctrl_reg <= i_wdata & LSC_EN_MASK;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      sink_timing_first_reg <= LSC_RESET_VAL;
    end else if (wr_timing) begin
      sink_timing_first_reg <= i_wdata;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    unique case (i_addr)
      LSC_DARK_DIM_ADDR: rdata_next = dark_dim_current_reg;
      LSC_FADE_LAW_ADDR: rdata_next = sink_fade_law_ctrl_reg;
      LSC_ENABLE_ADDR: rdata_next = sink_enable_ctrl_reg;
      LSC_TIMING1_ADDR: rdata_next = sink_timing_first_reg;
      default: rdata_next = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_rdata <= 8'h00;
    end else if (i_rd_en) begin
      o_rdata <= rdata_next;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_dim_active <= 1'b0;
    end else begin
      o_dim_active <= i_dim_timeout | i_dim_force;
    end
  end

  // dim code to the current dac
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_dark_dim_code <= 7'h00;
    end else begin
      o_dark_dim_code <= dark_dim_current_reg[6:0];
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_sink_fade_law <= 2'h0;
    end else begin
      o_sink_fade_law <= sink_fade_law_ctrl_reg[1:0];
    end
  end

  // 0.2 s tick base
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst || tick) begin
      tick_cnt_reg <= 32'h0;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h1;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  assign on_code = sink_timing_first_reg[7:6];
  always_comb begin
    unique case (on_code)
      2'h0: on_ticks = LSC_ON_TICKS_0;
      2'h1: on_ticks = LSC_ON_TICKS_1;
      2'h2: on_ticks = LSC_ON_TICKS_2;
      2'h3: on_ticks = LSC_ON_TICKS_3;
    endcase
  end

  // blink sequencers for sinks five to seven
  for (genvar g = 0; g < LSC_BLINK_SINKS; g++) begin : g_blink
    lsc_phase_type state_reg;
    logic [3:0] phase_cnt_reg;
    logic [1:0] off_code;
    logic [3:0] off_ticks;
    logic blink_en;
    logic restart;
    assign off_code = sink_timing_first_reg[2*g+1:2*g];
    // off code 00 holds the sink on
    assign blink_en = sink_enable_ctrl_reg[4+g] && (off_code != 2'h0);
    // enabling starts in the on phase so joint enables run in step
    assign restart = wr_enable && i_wdata[4+g] && !sink_enable_ctrl_reg[4+g];
    // code 00 never counts, the sequencer is held then
    always_comb begin
      unique case (off_code)
        2'h0, 2'h1: off_ticks = LSC_OFF_TICKS_1;
        2'h2: off_ticks = LSC_OFF_TICKS_2;
        2'h3: off_ticks = LSC_OFF_TICKS_3;
      endcase
    end
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst || restart || !blink_en) begin
        state_reg <= LSC_PHASE_ON;
        phase_cnt_reg <= 4'h0;
      end else if (tick) begin
        unique case (state_reg)
          LSC_PHASE_ON: begin
            if (phase_cnt_reg + 4'h1 >= on_ticks) begin
              state_reg <= LSC_PHASE_OFF;
              phase_cnt_reg <= 4'h0;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 4'h1;
            end
          end
          LSC_PHASE_OFF: begin
            if (phase_cnt_reg + 4'h1 >= off_ticks) begin
              state_reg <= LSC_PHASE_ON;
              phase_cnt_reg <= 4'h0;
            end else begin
              phase_cnt_reg <= phase_cnt_reg + 4'h1;
            end
          end
          default: begin
            state_reg <= LSC_PHASE_ON;
            phase_cnt_reg <= 4'h0;
          end
        endcase
      end
    end
    assign phase_on[g] = (state_reg == LSC_PHASE_ON);
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      o_sink_on <= 7'h00;
    end else begin
      o_sink_on <= {sink_enable_ctrl_reg[6:4] & phase_on, sink_enable_ctrl_reg[3:0]};
    end
  end
endmodule // lsc_regs
`default_nettype wire

// file: lsc_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module lsc_host_model (
  input wire logic i_clk,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_addr,
  output logic [7:0] o_data
);
  initial {o_wr, o_rd, o_addr, o_data} = 18'h0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    {o_wr, o_rd, o_addr, o_data} <= {w, !w, a, d};
    @(posedge i_clk);
    {o_wr, o_rd, o_addr, o_data} <= {2'h0, ~a, ~d};
  endtask
endmodule // lsc_host_model
`default_nettype wire

// file: lsc_regs_checker.sv
`timescale 1ns/10ps
`default_nettype none
module lsc_regs_checker (
  input wire logic i_core_clk,
  input wire logic i_nrst,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_dim_timeout,
  input wire logic i_dim_force,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic o_dim_active,
  input wire logic [6:0] o_dark_dim_code,
  input wire logic [6:0] o_sink_on,
  input wire logic [1:0] o_sink_fade_law
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  AST_DIM: assert property ($past(i_nrst) |-> o_dim_active == $past(i_dim_timeout | i_dim_force))
    else $error("dim select wrong");
  AST_CODE: assert property (i_wr_en && i_addr == 8'h0e |-> ##2 o_dark_dim_code == $past(i_wdata[6:0], 2))
    else $error("dim code wrong");
  AST_LAW: assert property (i_wr_en && i_addr == 8'h0f |-> ##2 o_sink_fade_law == $past(i_wdata[1:0], 2))
    else $error("fade law wrong");
  AST_LOW: assert property (i_wr_en && i_addr == 8'h10 |-> ##2 o_sink_on[3:0] == $past(i_wdata[3:0], 2))
    else $error("sink drive wrong");
  AST_OFF: assert property (i_wr_en && i_addr == 8'h10 && i_wdata[6:4] == 3'h0 |-> ##2 o_sink_on[6:4] == 3'h0)
    else $error("sink not off");
  AST_UNMAP: assert property (i_rd_en && !(i_addr inside {[8'h0e:8'h11]}) |=> o_rdata == 8'h00)
    else $error("unmapped read");
  AST_RSV: assert property (i_rd_en && i_addr inside {8'h0e, 8'h10} |=> !o_rdata[7])
    else $error("reserved bit set");
  AST_LAWRD: assert property (i_rd_en && i_addr == 8'h0f |=> o_rdata[7:2] == 6'h0)
    else $error("law reserved set");
  cover property (i_wr_en && i_addr == 8'h11);
  cover property (i_rd_en && i_addr == 8'h12);
  cover property ($rose(o_sink_on[6]));
  cover property ($fell(o_sink_on[6]));
endmodule // lsc_regs_checker
bind lsc_regs lsc_regs_checker i_lsc_regs_checker (.i_core_clk, .i_nrst, .i_wr_en, .i_rd_en,
  .i_dim_timeout, .i_dim_force, .i_addr, .i_wdata, .o_rdata, .o_dim_active, .o_dark_dim_code,
  .o_sink_on, .o_sink_fade_law);
`default_nettype wire

// file: tb_led_sink_control_registers.sv
`timescale 1ns/10ps
`default_nettype none
module tb_led_sink_control_registers;
  import lsc_pkg::*;
  logic clk = 0, nrst = 0, tmo = 0, frc = 0, rd_seen = 0, wr, rd, dim;
  logic [7:0] addr, wdata, rdata, d, exp_q[$];
  logic [6:0] code, son;
  logic [1:0] law;
  int n_mismatch = 0, cmp_count = 0, seed = 32'h325b6839, k, cnt[3];
  logic [7:0] adr_t[5] = '{8'h0e, 8'h0f, 8'h10, 8'h11, 8'h12};
  logic [7:0] msk_t[5] = '{8'h7f, 8'h03, 8'h7f, 8'hff, 8'h00};
  initial forever #12.5 clk = ~clk;
  lsc_host_model i_lsc_host_model (.i_clk(clk), .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_data(wdata));
  lsc_regs #(.TICK_CYCLES(10)) i_lsc_regs (.i_core_clk(clk), .i_nrst(nrst), .i_wr_en(wr),
    .i_rd_en(rd), .i_addr(addr), .i_wdata(wdata), .i_dim_timeout(tmo), .i_dim_force(frc),
    .o_rdata(rdata), .o_dim_active(dim), .o_dark_dim_code(code), .o_sink_fade_law(law),
    .o_sink_on(son));
  task automatic check(input logic [7:0] got, input logic [7:0] want);
    cmp_count++;
    if (got !== want) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_lsc_host_model.acc(1'b0, a, 8'h00);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) if (rd_seen) check(rdata, exp_q.pop_front());
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    foreach (adr_t[i]) rd_chk(adr_t[i], 8'h00);
    foreach (adr_t[i]) begin
      d = 8'($random(seed));
      i_lsc_host_model.acc(1'b1, adr_t[i], d);
      rd_chk(adr_t[i], d & msk_t[i]);
      if (i == 0) check(8'(code), d & msk_t[i]);
      if (i == 1) check(8'(law), d & msk_t[i]);
    end
    $display("test registers done");
    for (k = 0; k < 4; k++) begin
      @(posedge clk) {tmo, frc} <= k[1:0];
      repeat (2) @(negedge clk);
      check(8'(dim), 8'(k != 0));
    end
    $display("test dim done");
    i_lsc_host_model.acc(1'b1, 8'h11, 8'h10);
    i_lsc_host_model.acc(1'b1, 8'h10, 8'h70);
    repeat (60) @(posedge clk);
    cnt = '{0, 0, 0};
    repeat (80) @(negedge clk) for (k = 4; k < 7; k++) cnt[k - 4] += son[k];
    check(8'(cnt[0]), 8'h50);
    check(8'(cnt[1]), 8'h50);
    check(8'(cnt[2]), 8'(LSC_ON_TICKS_0 * 20));
    i_lsc_host_model.acc(1'b1, 8'h10, 8'h00);
    repeat (2) @(negedge clk);
    check(8'(son), 8'h00);
    $display("test blink done");
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    foreach (adr_t[i]) rd_chk(adr_t[i], 8'h00);
    repeat (2) @(negedge clk);
    check(8'(dim), 8'h01);
    $display("test reset done");
    complete_run;
  end
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    complete_run;
  end
endmodule // tb_led_sink_control_registers
`default_nettype wire
